// *** common/ocef_defines.svh ***
// Purpose: register offsets, field positions and timing constants
// Assumes: 25 MHz system clock, word-aligned Avalon-MM registers
// Notes: all times are kept in milliseconds
`ifndef OCEF_DEFINES_SVH
`define OCEF_DEFINES_SVH
// ==========================================================
// clock and time base
`define OCEF_CLK_HZ        25000000
`define OCEF_MS_PER_S      1000
`define OCEF_MS_CYCLES     (`OCEF_CLK_HZ / `OCEF_MS_PER_S)
`define OCEF_HS_OC_START_MS 16'h0028
`define OCEF_HS_EF_START_MS 16'h0032
`define OCEF_ACC_SHIFT     6
// ==========================================================
// register word index (byte address = index * 4)
`define OCEF_R_CTRL        4'h0
`define OCEF_R_OCL_SET     4'h1
`define OCEF_R_OCL_START   4'h2
`define OCEF_R_OCL_OP      4'h3
`define OCEF_R_OCH_SET     4'h4
`define OCEF_R_OCH_OP      4'h5
`define OCEF_R_EFL_SET     4'h6
`define OCEF_R_EFL_START   4'h7
`define OCEF_R_EFL_OP      4'h8
`define OCEF_R_EFH_SET     4'h9
`define OCEF_R_EFH_OP      4'hA
`define OCEF_R_STATUS      4'hB
`define OCEF_R_MEAS_A      4'hC
`define OCEF_R_MEAS_B      4'hD
`define OCEF_R_MEAS_C      4'hE
`define OCEF_R_MEAS_N      4'hF
// ==========================================================
// control fields and reset values
`define OCEF_CTRL_OC_INV   0
`define OCEF_CTRL_EF_INV   1
`define OCEF_CTRL_OC_CRV   4:2
`define OCEF_CTRL_EF_CRV   7:5
`define OCEF_CTRL_RST      8'h00
`define OCEF_SET_RST       16'hFFFF
`define OCEF_TIME_RST      16'h0064
`endif

// *** common/ocef_pkg.sv ***
// Purpose: shared types of the overcurrent and earth-fault timing block
// Assumes: nothing
// Notes: codes of the curve selection match the control field
package ocef_pkg;
  // ==========================================================
  // stage sequence, one-hot
  typedef enum logic [3:0] {
    OCEF_IDLE    = 4'b0001,
    OCEF_PICKUP  = 4'b0010,
    OCEF_STARTED = 4'b0100,
    OCEF_OPER    = 4'b1000
  } ocef_state_e;
  // ==========================================================
  // inverse curve selection
  typedef enum logic [2:0] {
    OCEF_NORMAL_INV  = 3'h0,
    OCEF_VERY_INV    = 3'h1,
    OCEF_EXTREME_INV = 3'h2,
    OCEF_LONG_INV    = 3'h3,
    OCEF_VENDOR_A    = 3'h4,
    OCEF_VENDOR_B    = 3'h5
  } ocef_curve_e;
endpackage

// *** logic/ocef_timing.sv ***
// Purpose: start and operate timing of two overcurrent and two
//          earth-fault stages, with an Avalon-MM register slave
// Assumes: current samples arrive on clk_sys from the measuring logic
// Notes: times in ms; inverse stages integrate a curve-dependent rate
//
// How it works
// - phase and neutral samples are registered each cycle for comparators
// - low-set overcurrent picks up above setting, starts after start time
// - low-set overcurrent operates after fixed or curve-computed delay
// - high-set overcurrent picks up above its setting, starts after 40 ms
// - high-set overcurrent operates its set time after starting
// - low-set earth fault picks up on neutral, starts after start time
// - low-set earth fault operates after fixed or curve delay
// - high-set earth fault picks up on neutral, starts after 50 ms
// - high-set earth fault operates the moment its time elapses
// - each low-set stage selects definite or inverse time on its own
// - six inverse curves: normal, very, extreme, long, two vendor
// - trip outputs come straight from stages, no interlock gating
// - measured currents readable by software for display and bus
`timescale 1ns/100ps
`include "ocef_defines.svh"

// ==========================================================
// one protection stage
module ocef_stage
#(
  parameter int W = 16
)
(
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic         tick_ms,
  input  wire logic [W-1:0] i_meas,
  input  wire logic [W-1:0] i_set,
  input  wire logic [15:0]  start_ms,
  input  wire logic [15:0]  op_ms,
  input  wire logic         inverse,
  input  wire logic [2:0]   curve,
  output logic              start_out,
  output logic              op_out
);
  ocef_pkg::ocef_state_e state_reg;
  ocef_pkg::ocef_state_e state_next;
  logic [15:0]           cnt_reg;
  logic [23:0]           acc_reg;
  logic                  over;
  logic                  start_done;
  logic                  op_done;
  logic [7:0]            rate;
  logic [23:0]           op_goal;

  // overcurrent multiple sets the inverse rate; no divider needed
  function automatic logic [7:0] curve_rate(input logic [2:0] crv,
                                            input logic [2:0] lvl);
    logic [7:0] r;
    r = 8'h01;
    unique case (crv)
      // very: 4x per octave, held at the top rate so 16x cannot wrap to 1
      ocef_pkg::OCEF_VERY_INV:
        r = (lvl == 3'h4) ? 8'h80 : 8'h01 << (lvl * 3'h2);
      // extreme: 3-bit shift amount, 16x gives 0 - 1, that is 7
      ocef_pkg::OCEF_EXTREME_INV:
        r = 8'h01 << (lvl * 3'h2 - {2'h0, lvl >= 3'h3});
      ocef_pkg::OCEF_LONG_INV:    r = {5'h00, lvl} + 8'h01;
      ocef_pkg::OCEF_VENDOR_A:    r = {4'h0, lvl, 1'b0} + 8'h02;
      ocef_pkg::OCEF_VENDOR_B:    r = 8'h01 << (lvl + (lvl >> 1));
      default:                    r = 8'h01 << lvl;  // normal inverse
    endcase
    return r;
  endfunction

  // multiple of setting in octave steps: 1x, 2x, 4x, 8x, 16x
  always_comb
  begin
    logic [2:0] lvl;
    lvl = 3'h0;
    if ({1'b0, i_meas} >= ({1'b0, i_set} << 1))
      lvl = 3'h1;
    if ({2'b0, i_meas} >= ({2'b0, i_set} << 2))
      lvl = 3'h2;
    if ({3'b0, i_meas} >= ({3'b0, i_set} << 3))
      lvl = 3'h3;
    if ({4'b0, i_meas} >= ({4'b0, i_set} << 4))
      lvl = 3'h4;
    rate = curve_rate(curve, lvl);
  end

  assign over       = i_meas > i_set;
  assign start_done = cnt_reg >= start_ms;
  assign op_goal    = {2'b00, op_ms, {`OCEF_ACC_SHIFT{1'b0}}};
  // definite time counts ms; inverse integrates rate against op_ms * 64
  assign op_done    = inverse ? (acc_reg >= op_goal)
                              : (cnt_reg >= op_ms);

  // stage sequence; a drop-out returns to idle from any state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ocef_pkg::OCEF_IDLE:
        if (over)
          state_next = ocef_pkg::OCEF_PICKUP;
      ocef_pkg::OCEF_PICKUP:
        if (!over)
          state_next = ocef_pkg::OCEF_IDLE;
        else if (start_done)
          state_next = ocef_pkg::OCEF_STARTED;
      ocef_pkg::OCEF_STARTED:
        if (!over)
          state_next = ocef_pkg::OCEF_IDLE;
        else if (op_done)
          state_next = ocef_pkg::OCEF_OPER;
      ocef_pkg::OCEF_OPER:
        if (!over)
          state_next = ocef_pkg::OCEF_IDLE;
      default:
        state_next = ocef_pkg::OCEF_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= ocef_pkg::OCEF_IDLE;
    else
      state_reg <= state_next;
  end

  // ms counter restarts on every state change
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      cnt_reg <= 16'h0000;
    else if (state_next != state_reg)
      cnt_reg <= 16'h0000;
    else if (tick_ms && cnt_reg != 16'hFFFF)
      cnt_reg <= cnt_reg + 16'h0001;
  end

  // inverse accumulator, only live while started
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      acc_reg <= 24'h00_0000;
    else if (state_reg != ocef_pkg::OCEF_STARTED)
      acc_reg <= 24'h00_0000;
    else if (tick_ms && acc_reg < 24'hFF_0000)
      acc_reg <= acc_reg + {16'h0000, rate};
  end

  // outputs registered from the next state, so they change with the state, straight from flops
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      start_out <= 1'b0;
      op_out    <= 1'b0;
    end
    else
    begin
      start_out <= state_next == ocef_pkg::OCEF_STARTED ||
                   state_next == ocef_pkg::OCEF_OPER;
      op_out    <= state_next == ocef_pkg::OCEF_OPER;
    end
  end

  // ==========================================================
  // checks
  start_before_op_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n) op_out |-> start_out)
    else $error("operate without start");
  op_from_started_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(op_out) |-> $past(state_reg) == ocef_pkg::OCEF_STARTED
                      && $past(op_done) && $past(over))
    else $error("operate did not follow an expired operate time");
  start_after_time_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(start_out) |-> $past(state_reg) == ocef_pkg::OCEF_PICKUP
                         && $past(cnt_reg) >= $past(start_ms))
    else $error("start raised before start time");
  drop_clears_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !over |=> !start_out && !op_out ##1 acc_reg == 24'h00_0000)
    else $error("stage not cleared after drop-out");
  no_pickup_low_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    state_reg == ocef_pkg::OCEF_IDLE && !over |=>
      state_reg == ocef_pkg::OCEF_IDLE)
    else $error("picked up below setting");
  definite_count_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    state_reg == ocef_pkg::OCEF_STARTED && !inverse && over
      && cnt_reg < op_ms |=> !op_out)
    else $error("definite operate too early");
endmodule

`timescale 1ns/100ps
// ==========================================================
// top: four stages and the register slave
module ocef_timing
#(
  parameter int W           = 16,
  parameter int TICK_CYCLES = `OCEF_MS_CYCLES
)
(
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] meas_a,
  input  wire logic [W-1:0] meas_b,
  input  wire logic [W-1:0] meas_c,
  input  wire logic [W-1:0] meas_n,
  input  wire logic [5:0]   address,
  input  wire logic         read,
  input  wire logic         write,
  input  wire logic [31:0]  writedata,
  input  wire logic [3:0]   byteenable,
  output logic [31:0]       readdata,
  output logic              waitrequest,
  output logic              oc_lo_start,
  output logic              oc_lo_trip,
  output logic              oc_hi_start,
  output logic              oc_hi_trip,
  output logic              ef_lo_start,
  output logic              ef_lo_trip,
  output logic              ef_hi_start,
  output logic              ef_hi_trip
);
  logic [W-1:0]  a_reg, b_reg, c_reg, n_reg, max_reg;
  logic [7:0]    ctrl_reg;
  logic [15:0]   cfg_reg [1:10];
  logic [31:0]   tick_cnt_reg;
  logic          tick_reg;
  logic [3:0]    idx;
  logic          wr_ok;
  logic [31:0]   rd_next;
  logic [7:0]    status;

  assign idx   = address[5:2];
  assign wr_ok = write && !waitrequest;

  // samples and phase maximum; samples one cycle of latency, maximum one more
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      a_reg   <= '0;
      b_reg   <= '0;
      c_reg   <= '0;
      n_reg   <= '0;
      max_reg <= '0;
    end
    else
    begin
      a_reg   <= meas_a;
      b_reg   <= meas_b;
      c_reg   <= meas_c;
      n_reg   <= meas_n;
      max_reg <= (a_reg > b_reg) ? ((a_reg > c_reg) ? a_reg : c_reg)
                                 : ((b_reg > c_reg) ? b_reg : c_reg);
    end
  end

  // 1 ms enable from the system clock
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
    end
    else
    begin
      tick_reg <= tick_cnt_reg == 32'(TICK_CYCLES - 1);
      if (tick_cnt_reg == 32'(TICK_CYCLES - 1))
        tick_cnt_reg <= 32'h0000_0000;
      else
        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  // ==========================================================
  // register file; low byte lane carries control, two lanes settings
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg <= `OCEF_CTRL_RST;
      for (int i = 1; i <= 10; i++)
        cfg_reg[i] <= (i == 1 || i == 4 || i == 6 || i == 9)
                      ? `OCEF_SET_RST : `OCEF_TIME_RST;
    end
    else if (wr_ok)
    begin
      if (idx == `OCEF_R_CTRL && byteenable[0])
        ctrl_reg <= writedata[7:0];
      else if (idx >= `OCEF_R_OCL_SET && idx <= `OCEF_R_EFH_OP)
      begin
        if (byteenable[0])
          cfg_reg[idx][7:0]  <= writedata[7:0];
        if (byteenable[1])
          cfg_reg[idx][15:8] <= writedata[15:8];
      end
    end
  end

  assign status = {ef_hi_trip, ef_hi_start, ef_lo_trip, ef_lo_start,
                   oc_hi_trip, oc_hi_start, oc_lo_trip, oc_lo_start};

  // read mux; status and measured values are read-only
  always_comb
  begin
    rd_next = 32'h0000_0000;
    unique case (idx)
      `OCEF_R_CTRL:   rd_next = {24'h00_0000, ctrl_reg};
      `OCEF_R_STATUS: rd_next = {24'h00_0000, status};
      `OCEF_R_MEAS_A: rd_next = 32'(a_reg);
      `OCEF_R_MEAS_B: rd_next = 32'(b_reg);
      `OCEF_R_MEAS_C: rd_next = 32'(c_reg);
      `OCEF_R_MEAS_N: rd_next = 32'(n_reg);
      default:        rd_next = {16'h0000, cfg_reg[idx]};
    endcase
  end

  // one wait cycle: waitrequest drops for exactly one cycle per request
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end
    else
    begin
      waitrequest <= !((read || write) && waitrequest);
      if (read && waitrequest)
        readdata <= rd_next;
    end
  end

  // ==========================================================
  // stages; trips leave the block with no gating of any kind
  ocef_stage #(.W(W)) u_oc_lo (
    .clk_sys(clk_sys), .arst_n(arst_n), .tick_ms(tick_reg),
    .i_meas(max_reg), .i_set(cfg_reg[`OCEF_R_OCL_SET]),
    .start_ms(cfg_reg[`OCEF_R_OCL_START]),
    .op_ms(cfg_reg[`OCEF_R_OCL_OP]),
    .inverse(ctrl_reg[`OCEF_CTRL_OC_INV]),
    .curve(ctrl_reg[`OCEF_CTRL_OC_CRV]),
    .start_out(oc_lo_start), .op_out(oc_lo_trip));
  ocef_stage #(.W(W)) u_oc_hi (
    .clk_sys(clk_sys), .arst_n(arst_n), .tick_ms(tick_reg),
    .i_meas(max_reg), .i_set(cfg_reg[`OCEF_R_OCH_SET]),
    .start_ms(`OCEF_HS_OC_START_MS),
    .op_ms(cfg_reg[`OCEF_R_OCH_OP]),
    .inverse(1'b0), .curve(3'h0),
    .start_out(oc_hi_start), .op_out(oc_hi_trip));
  ocef_stage #(.W(W)) u_ef_lo (
    .clk_sys(clk_sys), .arst_n(arst_n), .tick_ms(tick_reg),
    .i_meas(n_reg), .i_set(cfg_reg[`OCEF_R_EFL_SET]),
    .start_ms(cfg_reg[`OCEF_R_EFL_START]),
    .op_ms(cfg_reg[`OCEF_R_EFL_OP]),
    .inverse(ctrl_reg[`OCEF_CTRL_EF_INV]),
    .curve(ctrl_reg[`OCEF_CTRL_EF_CRV]),
    .start_out(ef_lo_start), .op_out(ef_lo_trip));
  ocef_stage #(.W(W)) u_ef_hi (
    .clk_sys(clk_sys), .arst_n(arst_n), .tick_ms(tick_reg),
    .i_meas(n_reg), .i_set(cfg_reg[`OCEF_R_EFH_SET]),
    .start_ms(`OCEF_HS_EF_START_MS),
    .op_ms(cfg_reg[`OCEF_R_EFH_OP]),
    .inverse(1'b0), .curve(3'h0),
    .start_out(ef_hi_start), .op_out(ef_hi_trip));

  // ==========================================================
  // checks
  bus_one_wait_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  tick_period_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    tick_reg |=> !tick_reg)
    else $error("tick wider than one cycle");
  meas_readback_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    read && waitrequest && idx == `OCEF_R_MEAS_N
      |=> readdata == 32'($past(n_reg)))
    else $error("neutral reading wrong");
  hs_start_fixed_a: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(ef_hi_start) |-> $past(u_ef_hi.cnt_reg) >= `OCEF_HS_EF_START_MS)
    else $error("high-set earth fault started early");
endmodule

// *** testbench/ocef_meas_src.sv ***
// Purpose: measuring front end feeding phase and neutral samples
// Assumes: one sample per clk_sys cycle, levels chosen by the bench
// Notes: registered like a converter output, so samples lag one cycle
`timescale 1ns/100ps

// ==========================================================
// sample source
module ocef_meas_src
#(
  parameter int W = 16
)
(
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] lvl_a,
  input  wire logic [W-1:0] lvl_b,
  input  wire logic [W-1:0] lvl_c,
  input  wire logic [W-1:0] lvl_n,
  output logic [W-1:0]      meas_a,
  output logic [W-1:0]      meas_b,
  output logic [W-1:0]      meas_c,
  output logic [W-1:0]      meas_n
);
  // a fresh sample every cycle; zero current while held in reset
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meas_a <= '0;
      meas_b <= '0;
      meas_c <= '0;
      meas_n <= '0;
    end
    else
    begin
      meas_a <= lvl_a;
      meas_b <= lvl_b;
      meas_c <= lvl_c;
      meas_n <= lvl_n;
    end
  end
endmodule

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench of the stage timing block
// Assumes: TICK_CYCLES shortened to 10, so 1 ms is 10 cycles
// Notes: time windows allow one short tick plus pipeline delay
`timescale 1ns/100ps
`include "ocef_defines.svh"

module tb_top;
  localparam int T = 10;
  logic        clk_sys;
  logic        arst_n;
  logic [15:0] lvl [4];
  logic [15:0] meas_a, meas_b, meas_c, meas_n;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  wire  [7:0]  flags;
  logic [31:0] rd;
  int          errors, samples_checked, seed, n;

  // ==========================================================
  // design, sample source, clock
  ocef_meas_src src (.clk_sys(clk_sys), .arst_n(arst_n), .lvl_a(lvl[0]),
    .lvl_b(lvl[1]), .lvl_c(lvl[2]), .lvl_n(lvl[3]), .meas_a(meas_a),
    .meas_b(meas_b), .meas_c(meas_c), .meas_n(meas_n));
  ocef_timing #(.TICK_CYCLES(T)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .meas_a(meas_a), .meas_b(meas_b), .meas_c(meas_c), .meas_n(meas_n),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .oc_lo_start(flags[0]),
    .oc_lo_trip(flags[1]), .oc_hi_start(flags[2]), .oc_hi_trip(flags[3]),
    .ef_lo_start(flags[4]), .ef_lo_trip(flags[5]), .ef_hi_start(flags[6]),
    .ef_hi_trip(flags[7]));
  // flags share the bit order of the status word
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // reporting
  task automatic summarize;
    $display("checked=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic timeout(input int got, input int lim);
    errors++;
    $display("MISMATCH t=%0t waited=%h bound=%h", $time, got, lim);
    summarize();
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_win(input int c, input int lo, input int hi);
    samples_checked++;
    if (c < lo || c > hi)
    begin
      errors++;
      $display("MISMATCH t=%0t cycles=%h window=%h..%h", $time, c, lo, hi);
    end
  endtask
  function automatic logic [31:0] rst_val(input int i);
    case (i)
      0: return 32'h0000_0000;
      1, 4, 6, 9: return 32'h0000_FFFF;
      11: return 32'h0000_0000;
      default: return 32'h0000_0064;
    endcase
  endfunction

  // ==========================================================
  // bus master: request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] idx,
                     input logic [31:0] wd, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_sys);
    address    <= {idx, 2'b00};
    writedata  <= wd;
    byteenable <= 4'hF;
    read       <= !wr;
    write      <= wr;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 50);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (k >= 50)
      timeout(k, 50);
  endtask
  // count edges until a flag is high; the bound guards against a hang
  task automatic wait_bit(input int b, input int lim, output int c);
    c = 0;
    while (flags[b] !== 1'b1 && c < lim)
    begin
      @(posedge clk_sys);
      c++;
    end
    n = c;
    if (c >= lim)
      timeout(c, lim);
  endtask

  // ==========================================================
  // one stage: boundary, start and operate timing, drop-out, abort
  task automatic run_stage(input int s, input logic [3:0] set_i, st_i,
                           op_i, input int st_ms, input int ph);
    int          op_ms, c;
    logic        hit;
    logic [15:0] setv;
    setv  = 16'(100 + ($random(seed) & 255));
    op_ms = 1 + ($random(seed) & 3);
    bus(1'b1, set_i, {16'h0000, setv}, rd);
    if (st_ms == 0)
    begin
      st_ms = 1 + ($random(seed) & 3);
      bus(1'b1, st_i, 32'(st_ms), rd);
    end
    bus(1'b1, op_i, 32'(op_ms), rd);
    lvl[ph] <= setv;
    repeat (3 * T) @(posedge clk_sys);
    cmp_val({31'h0, flags[2*s]}, 32'h0);
    lvl[ph] <= setv + 16'(1 + ($random(seed) & 511));
    wait_bit(2*s, st_ms*T + 20, c);
    cmp_win(c, (st_ms-1)*T, st_ms*T + 8);
    wait_bit(2*s+1, op_ms*T + 20, c);
    cmp_win(c, (op_ms-1)*T, op_ms*T + 4);
    bus(1'b0, `OCEF_R_STATUS, 32'h0, rd);
    cmp_val({30'h0, rd[2*s+:2]}, 32'h3);
    lvl[ph] <= 16'h0000;
    repeat (12) @(posedge clk_sys);
    cmp_val({30'h0, flags[2*s+:2]}, 32'h0);
    // abort: current just above setting, removed halfway to operate
    bus(1'b1, op_i, 32'h0000_000A, rd);
    lvl[ph] <= setv + 16'h0001;
    wait_bit(2*s, st_ms*T + 20, c);
    repeat (5 * T) @(posedge clk_sys);
    lvl[ph] <= 16'h0000;
    hit = 1'b0;
    repeat (12 * T)
    begin
      @(posedge clk_sys);
      hit |= flags[2*s+1];
    end
    cmp_val({31'h0, hit}, 32'h0);
    bus(1'b1, set_i, 32'h0000_FFFF, rd);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    errors = 0;
    samples_checked = 0;
    seed = 88;
    n = 0;
    arst_n = 1'b0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = '0;
    for (int i = 0; i < 4; i++)
      lvl[i] = 16'h0000;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    // reset values, then a refused write to the status word
    for (int i = 0; i < 12; i++)
    begin
      bus(1'b0, 4'(i), 32'h0, rd);
      cmp_val(rd, rst_val(i));
    end
    bus(1'b1, `OCEF_R_STATUS, 32'h0000_00FF, rd);
    bus(1'b0, `OCEF_R_STATUS, 32'h0, rd);
    cmp_val(rd, 32'h0000_0000);
    // measured values readable; settings at FFFF keep stages idle
    for (int i = 0; i < 4; i++)
      lvl[i] <= 16'($random(seed));
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, 4'(12 + i), 32'h0, rd);
      cmp_val(rd, {16'h0000, lvl[i]});
    end
    for (int i = 0; i < 4; i++)
      lvl[i] <= 16'h0000;
    // definite-time runs of all four stages
    repeat (2)
    begin
      run_stage(0, `OCEF_R_OCL_SET, `OCEF_R_OCL_START, `OCEF_R_OCL_OP, 0,
                ($random(seed) & 32'h7fff_ffff) % 3);
      run_stage(1, `OCEF_R_OCH_SET, `OCEF_R_OCL_START, `OCEF_R_OCH_OP, 40,
                ($random(seed) & 32'h7fff_ffff) % 3);
      run_stage(2, `OCEF_R_EFL_SET, `OCEF_R_EFL_START, `OCEF_R_EFL_OP, 0, 3);
      run_stage(3, `OCEF_R_EFH_SET, `OCEF_R_EFL_START, `OCEF_R_EFH_OP, 50, 3);
    end
    // every inverse curve on both low-set stages
    bus(1'b1, `OCEF_R_OCL_SET, 32'h0000_0032, rd);
    bus(1'b1, `OCEF_R_EFL_SET, 32'h0000_0032, rd);
    bus(1'b1, `OCEF_R_OCL_OP, 32'h0000_0001, rd);
    bus(1'b1, `OCEF_R_EFL_OP, 32'h0000_0001, rd);
    for (int c = 0; c < 6; c++)
    begin
      bus(1'b1, `OCEF_R_CTRL, 32'((c << 5) | (c << 2) | 3), rd);
      lvl[c % 3] <= 16'h0320;
      lvl[3] <= 16'h0320;
      wait_bit(1, 3000, n);
      cmp_val({31'h0, flags[0]}, 32'h1);
      wait_bit(5, 3000, n);
      cmp_val({31'h0, flags[4]}, 32'h1);
      lvl[c % 3] <= 16'h0000;
      lvl[3] <= 16'h0000;
      repeat (12) @(posedge clk_sys);
    end
    // overcurrent inverse must leave earth fault on definite time
    bus(1'b1, `OCEF_R_CTRL, 32'h0000_0001, rd);
    bus(1'b1, `OCEF_R_EFL_OP, 32'h0000_0014, rd);
    lvl[3] <= 16'h0320;
    wait_bit(4, 200, n);
    wait_bit(5, 300, n);
    cmp_win(n, 19 * T, 20 * T + 4);
    // second reset in mid-fault clears outputs and settings
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cmp_val({24'h0, flags}, 32'h0);
    arst_n <= 1'b1;
    bus(1'b0, `OCEF_R_EFL_OP, 32'h0, rd);
    cmp_val(rd, 32'h0000_0064);
    summarize();
  end
endmodule
